// File: verilog/ardi_pkg.sv
package ardi_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int MAX_CH = 8;
  localparam int CH_W = 3;
  localparam int BIT_W = 4;

  // ------------------------------------------------------------
  // positions and values
  // ------------------------------------------------------------
  localparam int DB_HBF_BIT = 14;
  localparam int DB_BYTE_BIT = 15;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [3:0] FIRST_BIT = 4'h0;
  localparam logic [2:0] CH_FIRST = 3'h0;
  localparam logic [2:0] CH_ONE_STEP = 3'h1;
  localparam logic [15:0] OE_WORD = 16'hFFFF;
  localparam logic [15:0] OE_BYTE = 16'h00FF;
  localparam logic [15:0] OE_NONE = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // synchroniser lane positions
  localparam int SYNC_W = 6;
  localparam int SY_CS = 0;
  localparam int SY_RD = 1;
  localparam int SY_CONV = 2;
  localparam int SY_IFSEL = 3;
  localparam int SY_BYTE = 4;
  localparam int SY_HBF = 5;

  // ------------------------------------------------------------
  // readout modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ardi_par = 2'h0,
    ardi_ser = 2'h1,
    ardi_byte = 2'h2
  } ardi_mode_t;

  // strap decode; select low with byte high is not listed, so
  // it falls back to the plain parallel mode
  function automatic ardi_mode_t decode_mode(input logic ifsel,
                                             input logic byte_strap);
    if (!ifsel)
      decode_mode = ardi_par;
    else if (byte_strap)
      decode_mode = ardi_byte;
    else
      decode_mode = ardi_ser;
  endfunction

endpackage

// File: verilog/ardi_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; first stage feeds only the second
module ardi_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // ------------------------------------------------------------
  // two flops, no reset: data path only
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end

endmodule

// File: verilog/ardi_readout.sv
`timescale 1ns/1ps
module ardi_readout #(
  parameter int CHANNELS = 8
) (
  // system clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link clock from the host
  input wire logic sclk,
  // converter core side
  input wire logic conversion_start,
  input wire logic conv_done,
  input wire logic [ardi_pkg::MAX_CH-1:0][ardi_pkg::DATA_W-1:0]
    conv_results,
  // strap
  input wire logic interface_select_pin,
  // host strobes
  input wire logic cs_n,
  input wire logic rd_n,
  // parallel data pins
  input wire logic [ardi_pkg::DATA_W-1:0] db_in,
  output logic [ardi_pkg::DATA_W-1:0] db_out,
  output logic [ardi_pkg::DATA_W-1:0] db_oe,
  // serial data pins
  output logic serial_out_a,
  output logic serial_out_a_oe,
  output logic serial_out_b,
  output logic serial_out_b_oe,
  // first channel flag pin
  output logic first_channel_flag,
  output logic first_channel_flag_oe,
  // status
  output logic busy,
  output ardi_pkg::ardi_mode_t mode,
  output logic results_fresh,
  output logic read_collision
);

  // ------------------------------------------------------------
  // local constants
  // ------------------------------------------------------------
  localparam logic [3:0] CH_COUNT = 4'(CHANNELS);
  localparam logic [2:0] HALF_CH = 3'(CHANNELS / 2);
  localparam logic [2:0] LAST_CH = 3'(CHANNELS - 1);

  // channel index advance with wrap at the channel count
  function automatic logic [2:0] ch_step(input logic [2:0] idx,
                                         input logic [2:0] by);
    logic [3:0] sum;
    sum = {1'h0, idx} + {1'h0, by};
    if (sum >= CH_COUNT)
      ch_step = 3'(sum - CH_COUNT);
    else
      ch_step = sum[2:0];
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [ardi_pkg::SYNC_W-1:0] raw_pins;
  logic [ardi_pkg::SYNC_W-1:0] sync_pins;

  assign raw_pins[ardi_pkg::SY_CS] = cs_n;
  assign raw_pins[ardi_pkg::SY_RD] = rd_n;
  assign raw_pins[ardi_pkg::SY_CONV] = conversion_start;
  assign raw_pins[ardi_pkg::SY_IFSEL] = interface_select_pin;
  assign raw_pins[ardi_pkg::SY_BYTE] = db_in[ardi_pkg::DB_BYTE_BIT];
  assign raw_pins[ardi_pkg::SY_HBF] = db_in[ardi_pkg::DB_HBF_BIT];

  ardi_sync #(
    .W(ardi_pkg::SYNC_W)
  ) u_sync (
    .clk(clk),
    .d(raw_pins),
    .q(sync_pins)
  );

  logic cs_s;
  logic rd_s;
  logic conv_s;
  logic high_byte_first_input;

  assign cs_s = sync_pins[ardi_pkg::SY_CS];
  assign rd_s = sync_pins[ardi_pkg::SY_RD];
  assign conv_s = sync_pins[ardi_pkg::SY_CONV];
  // line 14 is an input only while byte mode leaves it undriven
  assign high_byte_first_input = sync_pins[ardi_pkg::SY_HBF];

  // ------------------------------------------------------------
  // edge detection on synchronised strobes
  // ------------------------------------------------------------
  logic cs_q;
  logic rd_q;
  logic conv_q;

  // previous values, for edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cs_q <= 1'h1;
      rd_q <= 1'h1;
      conv_q <= 1'h0;
    end else begin
      cs_q <= cs_s;
      rd_q <= rd_s;
      conv_q <= conv_s;
    end
  end

  logic conv_rise;
  logic par_mode;
  logic rd_fall;
  logic rd_rise;
  logic cs_fall;
  logic load;

  assign conv_rise = conv_s && !conv_q;
  assign par_mode = (mode == ardi_pkg::ardi_par) ||
                    (mode == ardi_pkg::ardi_byte);
  // a read is a rd fall seen while cs is low
  assign rd_fall = par_mode && !cs_s && rd_q && !rd_s;
  assign rd_rise = par_mode && !cs_q && !rd_q && rd_s;
  assign cs_fall = cs_q && !cs_s;
  // new results only on the busy falling edge
  assign load = busy && conv_done && !conv_rise;

  // ------------------------------------------------------------
  // mode straps
  // ------------------------------------------------------------
  // sampled through reset so that the mode is stable before any
  // read; hold reset for at least three clk edges
  always_ff @(posedge clk) begin
    if (!nrst)
      mode <= ardi_pkg::decode_mode(sync_pins[ardi_pkg::SY_IFSEL],
                                    sync_pins[ardi_pkg::SY_BYTE]);
  end

  // ------------------------------------------------------------
  // busy and result registers
  // ------------------------------------------------------------
  // start wins over a done in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst)
      busy <= 1'h0;
    else if (conv_rise)
      busy <= 1'h1;
    else if (conv_done)
      busy <= 1'h0;
  end

  logic [ardi_pkg::DATA_W-1:0] res [ardi_pkg::MAX_CH];

  // output registers change only at load, so reads while busy
  // is high still return the previous set
  always_ff @(posedge clk) begin
    if (load) begin
      for (int i = 0; i < ardi_pkg::MAX_CH; i++)
        res[i] <= conv_results[i];
    end
  end

  // async clear for the link side, one cycle per load
  logic ptr_clear;

  always_ff @(posedge clk) begin
    ptr_clear <= !nrst || load;
  end

  // ------------------------------------------------------------
  // parallel and byte readout
  // ------------------------------------------------------------
  logic [2:0] par_ptr;
  logic par_half;

  // pointer to the next word and byte to put on the bus
  always_ff @(posedge clk) begin
    if (!nrst || load) begin
      par_ptr <= ardi_pkg::CH_FIRST;
      par_half <= 1'h0;
    end else if (rd_fall) begin
      if (mode == ardi_pkg::ardi_byte && !par_half) begin
        par_half <= 1'h1;
      end else begin
        par_half <= 1'h0;
        par_ptr <= ch_step(par_ptr, ardi_pkg::CH_ONE_STEP);
      end
    end
  end

  logic upper_sel;
  logic [ardi_pkg::BYTE_W-1:0] byte_val;

  // first transfer of a pair is the upper byte when line 14 is high
  assign upper_sel = par_half ^ high_byte_first_input;
  assign byte_val = upper_sel ?
    res[par_ptr][ardi_pkg::DATA_W-1:ardi_pkg::BYTE_W] :
    res[par_ptr][ardi_pkg::BYTE_W-1:0];

  // data updated on each read fall
  always_ff @(posedge clk) begin
    if (!nrst)
      db_out <= '0;
    else if (rd_fall) begin
      if (mode == ardi_pkg::ardi_byte)
        db_out <= {ardi_pkg::BYTE_ZERO, byte_val};
      else
        db_out <= res[par_ptr];
    end
  end

  // drive only while both strobes are low; a cs rise releases
  always_ff @(posedge clk) begin
    if (!nrst || !par_mode || cs_s || rd_s)
      db_oe <= ardi_pkg::OE_NONE;
    else if (mode == ardi_pkg::ardi_byte)
      db_oe <= ardi_pkg::OE_BYTE;
    else
      db_oe <= ardi_pkg::OE_WORD;
  end

  logic par_flag;
  logic ch1_done;

  // channel 1 fully read once the pointer sits on the next word
  assign ch1_done = (par_ptr == ch_step(ardi_pkg::CH_FIRST,
                                        ardi_pkg::CH_ONE_STEP)) &&
                    !par_half;

  // load wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst)
      par_flag <= 1'h0;
    else if (load)
      par_flag <= 1'h1;
    else if (rd_rise && ch1_done)
      par_flag <= 1'h0;
  end

  // ------------------------------------------------------------
  // output enables for serial and flag pins
  // ------------------------------------------------------------
  // registered from the synchronised cs, so they trail the pin
  // by two to three clk cycles
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serial_out_a_oe <= 1'h0;
      serial_out_b_oe <= 1'h0;
      first_channel_flag_oe <= 1'h0;
    end else begin
      serial_out_a_oe <= (mode == ardi_pkg::ardi_ser) && !cs_s;
      serial_out_b_oe <= (mode == ardi_pkg::ardi_ser) && !cs_s;
      first_channel_flag_oe <= !cs_s;
    end
  end

  // ------------------------------------------------------------
  // status
  // ------------------------------------------------------------
  // fresh from load until the last channel has been read out on the parallel bus; serial reads never clear it
  always_ff @(posedge clk) begin
    if (!nrst)
      results_fresh <= 1'h0;
    else if (load)
      results_fresh <= 1'h1;
    else if (rd_fall && par_ptr == LAST_CH &&
             (par_half || mode != ardi_pkg::ardi_byte))
      results_fresh <= 1'h0;
  end

  // a strobe edge in the load cycle may return a torn result;
  // sticky until the next conversion start, detection wins
  always_ff @(posedge clk) begin
    if (!nrst)
      read_collision <= 1'h0;
    else if (load && (rd_fall || cs_fall))
      read_collision <= 1'h1;
    else if (conv_rise)
      read_collision <= 1'h0;
  end

  // ------------------------------------------------------------
  // serial link domain
  // ------------------------------------------------------------
  // cs_n frames the link and is timed against sclk by the host,
  // so it is used here without synchronising; sclk may stop
  // between frames, and the pointer is cleared from the clk side
  logic [3:0] bit_idx;
  logic [2:0] word_idx;
  logic ser_flag;

  // bit and word position, advanced on each sclk rise in a frame
  always_ff @(posedge sclk or posedge ptr_clear) begin
    if (ptr_clear) begin
      bit_idx <= ardi_pkg::FIRST_BIT;
      word_idx <= ardi_pkg::CH_FIRST;
    end else if (!cs_n) begin
      if (bit_idx == ardi_pkg::LAST_BIT) begin
        bit_idx <= ardi_pkg::FIRST_BIT;
        word_idx <= ch_step(word_idx, ardi_pkg::CH_ONE_STEP);
      end else begin
        bit_idx <= bit_idx + 4'h1;
      end
    end
  end

  // high from load, low after the 16th fall of word 0, and never
  // high again before the next load, whichever output is read
  always_ff @(negedge sclk or posedge ptr_clear) begin
    if (ptr_clear)
      ser_flag <= 1'h1;
    else if (!cs_n && word_idx == ardi_pkg::CH_FIRST &&
             bit_idx == ardi_pkg::LAST_BIT)
      ser_flag <= 1'h0;
  end

  // result bits picked from the held registers; the msb is
  // present as soon as the frame opens, with no sclk edge needed
  logic [3:0] bit_pos;

  assign bit_pos = ardi_pkg::LAST_BIT - bit_idx;
  assign serial_out_a = res[word_idx][bit_pos];
  assign serial_out_b = res[ch_step(word_idx, HALF_CH)][bit_pos];

  // flag value follows the active mode
  assign first_channel_flag = (mode == ardi_pkg::ardi_ser) ?
                              ser_flag : par_flag;

endmodule

// File: testbench/ardi_readout_sva.sv
`timescale 1ns/1ps
module ardi_readout_sva (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // converter and host strobes
  input wire logic conversion_start,
  input wire logic conv_done,
  input wire logic cs_n,
  input wire logic rd_n,
  // pin enables and status
  input wire logic [ardi_pkg::DATA_W-1:0] db_oe,
  input wire logic serial_out_a_oe,
  input wire logic serial_out_b_oe,
  input wire logic first_channel_flag_oe,
  input wire logic busy,
  input wire ardi_pkg::ardi_mode_t mode,
  input wire logic results_fresh
);
  // ----
  // pin drive and busy checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // five edges cover the two sync flops and the output flop
  AST_CS_FLOAT: assert property (cs_n [*5] |-> db_oe == 16'h0000)
    else $error("bus driven with cs high");
  AST_RD_FLOAT: assert property (rd_n [*5] |-> db_oe == 16'h0000)
    else $error("bus driven with rd high");
  AST_SER_QUIET: assert property (mode == ardi_pkg::ardi_ser |->
    db_oe == 16'h0000) else $error("bus driven in serial mode");
  AST_PAR_SER_OFF: assert property (mode != ardi_pkg::ardi_ser |->
    !serial_out_a_oe && !serial_out_b_oe)
    else $error("serial pins driven outside serial mode");
  AST_BYTE_LANES: assert property (mode == ardi_pkg::ardi_byte &&
    db_oe != 16'h0000 |-> db_oe == 16'h00FF)
    else $error("byte mode lanes wrong");
  AST_WORD_LANES: assert property (mode == ardi_pkg::ardi_par &&
    db_oe != 16'h0000 |-> db_oe == 16'hFFFF)
    else $error("word mode lanes wrong");
  AST_SER_ENABLE: assert property (mode == ardi_pkg::ardi_ser &&
    $fell(cs_n) |-> ##[1:4] (serial_out_a_oe && serial_out_b_oe))
    else $error("serial outputs not enabled after cs fall");
  AST_FLAG_FLOAT: assert property (cs_n [*5] |->
    !first_channel_flag_oe) else $error("flag driven with cs high");
  AST_BUSY_RISE: assert property ($rose(conversion_start) |->
    ##[2:4] busy) else $error("busy late after start");
  AST_BUSY_FALL: assert property (busy && conv_done &&
    !conversion_start && !$past(conversion_start) &&
    !$past(conversion_start, 2) |=> !busy && results_fresh)
    else $error("busy or load wrong at conversion end");
endmodule

// File: testbench/ardi_host.sv
`timescale 1ns/1ps
module ardi_host (
  // clocks
  input wire logic clk,
  input wire logic sclk_src,
  // device pins
  input wire logic [15:0] db_out,
  input wire logic [15:0] db_oe,
  input wire logic serial_out_a,
  input wire logic serial_out_a_oe,
  input wire logic serial_out_b,
  input wire logic serial_out_b_oe,
  input wire logic first_channel_flag,
  input wire logic first_channel_flag_oe,
  // straps held by the host
  input wire logic byte_strap,
  input wire logic hbf,
  // host strobes and bus level
  output logic cs_n = 1'b1,
  output logic rd_n = 1'b1,
  output logic sclk,
  output logic [15:0] db_in,
  // captured results
  output logic [16:0] got = 17'h00000,
  output logic got_t = 1'b0
);
  logic en = 1'b0;
  wire logic fl = first_channel_flag_oe ? first_channel_flag : 1'bx;
  wire logic sa = serial_out_a_oe ? serial_out_a : 1'bx;
  wire logic sb = serial_out_b_oe ? serial_out_b : 1'bx;
  // link clock only runs inside frames and idles high, so the
  // first edge of a frame is a fall that samples the msb
  assign sclk = sclk_src | ~en;
  // released lines 13 to 0 show the inverse of the last value, lines 15 and 14 the straps
  assign db_in = (db_oe & db_out) |
    (~db_oe & {byte_strap, hbf, ~db_out[13:0]});
  // joined strobe frames one transfer
  task automatic par_read(input logic bmode);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    got <= {fl, bmode ? {8'h00, db_in[7:0]} : db_in};
    got_t <= ~got_t;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  // sample on falling link edges, 16 per word
  task automatic ser_word(input logic useb, input logic keep);
    logic [15:0] sh;
    logic f;
    int i;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(posedge sclk_src) en = 1'b1;
    for (i = 0; i < 16; i++) begin
      @(negedge sclk);
      sh = {sh[14:0], useb ? sb : sa};
      if (i == 0) f = fl;
    end
    // let the 16th rise through so the pointer moves on
    @(posedge sclk_src) en = 1'b0;
    got <= {f, sh};
    got_t <= ~got_t;
    if (!keep) begin
      @(posedge clk);
      cs_n <= 1'b1;
      repeat (5) @(posedge clk);
    end
  endtask
endmodule

// File: testbench/ardi_readout_tb.sv
`timescale 1ns/1ps
module ardi_readout_tb;
  localparam int CH = 8;
  logic clk = 0, sclk_src = 0, nrst = 0, conversion_start = 0;
  logic conv_done = 0, ifsel = 0, byte_strap = 0, hbf = 0;
  logic cs_n, rd_n, sclk, sa, sa_oe, sb, sb_oe, fl, fl_oe;
  logic busy, results_fresh, got_t, collision;
  logic [16:0] got;
  logic [15:0] db_in, db_out, db_oe;
  logic [7:0][15:0] res = '0, cur = '0;
  ardi_pkg::ardi_mode_t mode;
  logic [16:0] q[$];
  int failures = 0, compares = 0, k, h;
  // ----
  // clocks and instances
  // ----
  always #12.5 clk = ~clk;
  // offset start keeps the link clock out of phase with clk
  initial begin
    #3.3;
    forever #7.5 sclk_src = ~sclk_src;
  end
  ardi_readout #(.CHANNELS(CH)) i_ardi_readout (.clk(clk), .nrst(nrst),
    .sclk(sclk), .conversion_start(conversion_start),
    .conv_done(conv_done), .conv_results(res),
    .interface_select_pin(ifsel), .cs_n(cs_n), .rd_n(rd_n),
    .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .serial_out_a(sa),
    .serial_out_a_oe(sa_oe), .serial_out_b(sb), .serial_out_b_oe(sb_oe),
    .first_channel_flag(fl), .first_channel_flag_oe(fl_oe),
    .busy(busy), .mode(mode), .results_fresh(results_fresh),
    .read_collision(collision));
  ardi_host i_ardi_host (.clk(clk), .sclk_src(sclk_src),
    .db_out(db_out), .db_oe(db_oe), .serial_out_a(sa),
    .serial_out_a_oe(sa_oe), .serial_out_b(sb), .serial_out_b_oe(sb_oe),
    .first_channel_flag(fl), .first_channel_flag_oe(fl_oe),
    .byte_strap(byte_strap), .hbf(hbf), .cs_n(cs_n), .rd_n(rd_n),
    .sclk(sclk), .db_in(db_in), .got(got), .got_t(got_t));
  // ----
  // checking
  // ----
  // an x in the noted flag means the flag is not judged
  // the port settles from x at time zero, which is not a result
  always @(got_t) begin
    if ($time > 0) begin
      compares++;
      if (q.size() == 0 || got[15:0] !== q[0][15:0] ||
          (q[0][16] !== 1'bx && got[16] !== q[0][16])) begin
        failures++;
        $display("CHECK FAILED at %0t: got %h", $time, got);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  task automatic complete_run();
    if (q.size() != 0) failures++;
    // no read was placed on a load edge, so no collision may show
    compares++;
    if (collision !== 1'b0) begin
      failures++;
      $display("CHECK FAILED at %0t: collision flagged", $time);
    end
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    complete_run();
  end
  // ----
  // stimulus
  // ----
  task automatic do_reset(input logic s, input logic b);
    @(posedge clk);
    nrst <= 1'b0;
    ifsel <= s;
    byte_strap <= b;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic done_conv();
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk);
    cur = res;
  endtask
  // new random results, ended now or left busy
  task automatic convert(input logic finish);
    int i;
    @(posedge clk);
    for (i = 0; i < CH; i++) res[i] <= 16'($urandom);
    conversion_start <= 1'b1;
    repeat (3) @(posedge clk);
    conversion_start <= 1'b0;
    for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
    if (finish) done_conv();
  endtask
  // word or byte reads from channel 1 upward
  task automatic rd_seq(input int n, input logic bm);
    int i;
    logic [15:0] v;
    for (i = 0; i < n; i++) begin
      v = cur[i % CH];
      if (bm) begin
        q.push_back({i == 0, 8'h00, hbf ? v[15:8] : v[7:0]});
        i_ardi_host.par_read(1'b1);
        q.push_back({i == 0, 8'h00, hbf ? v[7:0] : v[15:8]});
        i_ardi_host.par_read(1'b1);
      end else begin
        q.push_back({i == 0, v});
        i_ardi_host.par_read(1'b0);
      end
    end
  endtask
  initial begin
    k = $urandom(32'h1912);
    do_reset(1'b0, 1'b0);
    convert(1'b1);
    rd_seq(3, 1'b0);
    convert(1'b1);
    convert(1'b0);
    rd_seq(2, 1'b0);
    done_conv();
    rd_seq(CH, 1'b0);
    do_reset(1'b1, 1'b1);
    for (h = 1; h >= 0; h--) begin
      hbf <= h[0];
      convert(1'b1);
      rd_seq(CH, 1'b1);
    end
    do_reset(1'b1, 1'b0);
    convert(1'b1);
    for (k = 0; k < CH; k++) begin
      q.push_back({k == 0, cur[k]});
      i_ardi_host.ser_word(1'b0, 1'b0);
    end
    convert(1'b1);
    for (k = 0; k < CH; k++) begin
      q.push_back({k == 0, cur[(k + CH / 2) % CH]});
      i_ardi_host.ser_word(1'b1, k < CH - 1);
    end
    complete_run();
  end
endmodule
bind ardi_readout ardi_readout_sva i_ardi_readout_sva (.clk(clk),
  .nrst(nrst), .conversion_start(conversion_start),
  .conv_done(conv_done), .cs_n(cs_n), .rd_n(rd_n), .db_oe(db_oe),
  .serial_out_a_oe(serial_out_a_oe), .serial_out_b_oe(serial_out_b_oe),
  .first_channel_flag_oe(first_channel_flag_oe), .busy(busy),
  .mode(mode), .results_fresh(results_fresh));
